// ### pkg/plis_regs.svh
/*
  size, field and reset constants for the priority level interrupt switch.
  assumes a single mclk domain; included by bare name.
*/
`ifndef PLIS_REGS_SVH
`define PLIS_REGS_SVH
`define PLIS_NUM_LEVELS   4
`define PLIS_LEVEL_W      2
`define PLIS_NUM_GPR      8
`define PLIS_GPR_W        16
`define PLIS_DEV_W        8
`define PLIS_NUM_DEV      256
`define PLIS_ADDR_W       16
`define PLIS_PHYS_W       24
`define PLIS_LSW_W        16
`define PLIS_LEVEL_RESET  2'h0
`define PLIS_MASK_RESET   4'h0
`define PLIS_ENTRY_SHIFT  2
`endif

// ### pkg/plis_pkg.sv
/*
  types shared by the priority level interrupt switch modules.
  assumes plis_regs.svh constants.
*/
`default_nettype none
`include "plis_regs.svh"
package plis_pkg;
  typedef enum logic [1:0] {
    PLIS_RUN    = 2'b00,
    PLIS_SWITCH = 2'b01,
    PLIS_CLASS  = 2'b10
  } plis_state_t;
  typedef logic [`PLIS_GPR_W-1:0] plis_word_t;
endpackage
`default_nettype wire

// ### pkg/plis_xlat_if.sv
/*
  carrier between the switch and its address translator.
  assumes one mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plis_regs.svh"
interface plis_xlat_if;
  logic [`PLIS_ADDR_W-1:0] logical;
  logic [`PLIS_PHYS_W-1:0] physical;
  logic                    enable;
  modport ctl (output logical, output enable, input physical);
  modport xlt (input logical, input enable, output physical);
endinterface
`default_nettype wire

// ### design/plis_xlat.sv
/*
  address translator: 16-bit logical byte address to 24-bit physical.
  assumes the segment base table is loaded by the switch top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plis_regs.svh"
module plis_xlat #(
  parameter int SEG_W = 3
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    seg_we,
  input  wire logic [SEG_W-1:0]        seg_sel,
  input  wire logic [`PLIS_PHYS_W-`PLIS_ADDR_W+SEG_W-1:0] seg_base,
  plis_xlat_if.xlt                     xif
);
  localparam int BW = `PLIS_PHYS_W - `PLIS_ADDR_W + SEG_W;
  logic [BW-1:0] base_tab [2**SEG_W];
  logic [BW-1:0] next_entry;
  // segment base table write
  always_comb begin
    next_entry = seg_base;
  end
  always_ff @(posedge mclk) begin
    if (seg_we) begin
      base_tab[seg_sel] <= next_entry;
    end
  end
  // top bits pick a segment, rest is offset; bypass is zero extension
  always_comb begin
    if (xif.enable) begin
      xif.physical = {base_tab[xif.logical[`PLIS_ADDR_W-1 -: SEG_W]],
                      xif.logical[`PLIS_ADDR_W-SEG_W-1:0]};
    end else begin
      xif.physical = {{(`PLIS_PHYS_W-`PLIS_ADDR_W){1'b0}}, xif.logical};
    end
  end
  a_bypass_zero_ext: assert property (@(posedge mclk) disable iff (sys_rst)
    !xif.enable |-> xif.physical[`PLIS_PHYS_W-1:`PLIS_ADDR_W] == '0)
    else $error("bypass address not zero extended");
endmodule
`default_nettype wire

// ### design/plis_top.sv
/*
  four-level priority interrupt switch with banked level context.
  assumes device requests arrive from outside mclk and are synchronised here;
  the processor core supplies register and mask writes on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plis_regs.svh"
module plis_top #(
  parameter int NL    = `PLIS_NUM_LEVELS,
  parameter int SEG_W = 3,
  parameter bit XLAT_PRESENT = 1'b1
) (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     dev_req,
  input  wire logic [`PLIS_DEV_W-1:0]   dev_addr,
  output logic                          dev_ack,
  input  wire logic                     level_mask_we,
  input  wire logic [NL-1:0]            level_mask_in,
  input  wire logic                     dev_cfg_we,
  input  wire logic [`PLIS_DEV_W-1:0]   dev_cfg_addr,
  input  wire logic                     dev_cfg_enable,
  input  wire logic [`PLIS_LEVEL_W-1:0] dev_cfg_level,
  input  wire logic                     prog_switch,
  input  wire logic [`PLIS_LEVEL_W-1:0] prog_level,
  input  wire logic                     class_set,
  input  wire logic                     class_reset,
  input  wire logic                     gpr_we,
  input  wire logic [2:0]               gpr_sel,
  input  wire plis_pkg::plis_word_t     gpr_wdata,
  input  wire logic                     ptr_we,
  input  wire plis_pkg::plis_word_t     ptr_wdata,
  input  wire logic                     lsw_we,
  input  wire plis_pkg::plis_word_t     lsw_wdata,
  input  wire logic [`PLIS_ADDR_W-1:0]  mem_addr,
  input  wire logic                     xlat_en,
  input  wire logic                     seg_we,
  input  wire logic [SEG_W-1:0]         seg_sel,
  input  wire logic [`PLIS_PHYS_W-`PLIS_ADDR_W+SEG_W-1:0] seg_base,
  output logic [`PLIS_LEVEL_W-1:0]      active_level,
  output logic                          class_active,
  output logic                          vector_valid,
  output logic [`PLIS_ADDR_W-1:0]       vector_entry,
  output plis_pkg::plis_word_t          gpr_rdata,
  output plis_pkg::plis_word_t          level_instruction_pointer,
  output plis_pkg::plis_word_t          level_status_word,
  output logic [`PLIS_PHYS_W-1:0]       phys_addr,
  output logic [NL-1:0]                 level_mask
);
  // per-level banks, duplicated for each level
  plis_pkg::plis_word_t gpr  [NL][`PLIS_NUM_GPR];
  plis_pkg::plis_word_t ptr  [NL];
  plis_pkg::plis_word_t lsw  [NL];
  // per-device level assignment and enable, single system copy
  logic [`PLIS_LEVEL_W-1:0] dev_level [`PLIS_NUM_DEV];
  logic [`PLIS_NUM_DEV-1:0] dev_en;
  logic                     req_s1, req_s2;
  logic [`PLIS_DEV_W-1:0]   addr_s1, addr_s2;
  logic [NL-1:0]            next_level_mask;
  plis_pkg::plis_state_t    state, next_state;
  logic [`PLIS_LEVEL_W-1:0] next_active_level;
  logic                     next_class_active, next_vector_valid, next_dev_ack;
  logic [`PLIS_ADDR_W-1:0]  next_vector_entry;
  logic [`PLIS_LEVEL_W-1:0] req_level;
  logic                     req_ok;
  plis_xlat_if              xif ();

  // request pins pass two flip-flops
  always_ff @(posedge mclk) begin
    req_s1  <= dev_req;
    req_s2  <= req_s1;
    addr_s1 <= dev_addr;
    addr_s2 <= addr_s1;
  end

  // device assignment table; may be rewritten at any time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dev_en <= '0;
    end else if (dev_cfg_we) begin
      dev_en[dev_cfg_addr] <= dev_cfg_enable;
    end
  end
  always_ff @(posedge mclk) begin
    if (dev_cfg_we) begin
      dev_level[dev_cfg_addr] <= dev_cfg_level;
    end
  end

  // acceptance: device enabled, its level enabled, it outranks the active one, and no class interrupt is active
  always_comb begin
    req_level = dev_level[addr_s2];
    req_ok    = req_s2 && !dev_ack && dev_en[addr_s2] && level_mask[req_level]
                && (req_level < active_level) && !class_active;
  end

  // level switch state machine
  always_comb begin
    next_state        = state;
    next_active_level = active_level;
    next_class_active = class_active;
    next_vector_valid = 1'b0;
    next_vector_entry = vector_entry;
    next_dev_ack      = 1'b0;
    next_level_mask   = level_mask_we ? level_mask_in : level_mask;
    if (class_set) begin
      next_class_active = 1'b1;
    end else if (class_reset) begin
      next_class_active = 1'b0;
    end
    case (state)
      plis_pkg::PLIS_RUN: begin
        if (req_ok) begin
          next_active_level = req_level;
          next_vector_entry = `PLIS_ADDR_W'({addr_s2, `PLIS_ENTRY_SHIFT'(0)});
          next_vector_valid = 1'b1;
          next_dev_ack      = 1'b1;
          next_state        = plis_pkg::PLIS_SWITCH;
        end else if (prog_switch && !class_active) begin
          next_active_level = prog_level;
        end
        if (class_active || class_set) begin
          next_state = plis_pkg::PLIS_CLASS;
        end
      end
      plis_pkg::PLIS_SWITCH: begin
        next_state = class_active ? plis_pkg::PLIS_CLASS : plis_pkg::PLIS_RUN;
      end
      plis_pkg::PLIS_CLASS: begin
        if (!next_class_active) begin
          next_state = plis_pkg::PLIS_RUN;
        end
      end
      default: next_state = plis_pkg::PLIS_RUN;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state        <= plis_pkg::PLIS_RUN;
      active_level <= `PLIS_LEVEL_RESET;
      class_active <= 1'b0;
      vector_valid <= 1'b0;
      vector_entry <= '0;
      dev_ack      <= 1'b0;
      level_mask   <= NL'(`PLIS_MASK_RESET);
    end else begin
      state        <= next_state;
      active_level <= next_active_level;
      class_active <= next_class_active;
      vector_valid <= next_vector_valid;
      vector_entry <= next_vector_entry;
      dev_ack      <= next_dev_ack;
      level_mask   <= next_level_mask;
    end
  end

  // writes go only to the active bank; other banks hold their context
  always_ff @(posedge mclk) begin
    if (gpr_we) begin
      gpr[active_level][gpr_sel] <= gpr_wdata;
    end
    if (ptr_we) begin
      ptr[active_level] <= ptr_wdata;
    end
    if (lsw_we) begin
      lsw[active_level] <= lsw_wdata;
    end
  end

  // registered views of the newly active bank and translated address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gpr_rdata                 <= '0;
      level_instruction_pointer <= '0;
      level_status_word         <= '0;
      phys_addr                 <= '0;
    end else begin
      gpr_rdata                 <= gpr[next_active_level][gpr_sel];
      level_instruction_pointer <= ptr[next_active_level];
      level_status_word         <= lsw[next_active_level];
      phys_addr                 <= xif.physical;
    end
  end

  assign xif.logical = mem_addr;
  assign xif.enable  = XLAT_PRESENT && xlat_en;
  plis_xlat #(.SEG_W(SEG_W)) plis_xlat_inst (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .seg_we   (seg_we),
    .seg_sel  (seg_sel),
    .seg_base (seg_base),
    .xif      (xif.xlt)
  );

  // a request taken in RUN must vector, acknowledge and switch on the next edge
  sequence s_accept;
    req_ok && state == plis_pkg::PLIS_RUN && !class_set;
  endsequence
  // a program switch that nothing overrides and no pointer write accompanies
  sequence s_prog_switch;
    prog_switch && state == plis_pkg::PLIS_RUN && !class_active && !req_ok && !ptr_we;
  endsequence
  a_accept_vector: assert property (@(posedge mclk) disable iff (sys_rst)
    s_accept |=> vector_valid && dev_ack && vector_entry == {$past(addr_s2), 2'b00})
    else $error("accepted request did not vector");
  a_accept_level: assert property (@(posedge mclk) disable iff (sys_rst)
    s_accept |=> active_level == $past(req_level))
    else $error("level not switched on accept");
  a_priority_only_up: assert property (@(posedge mclk) disable iff (sys_rst)
    vector_valid |-> active_level < $past(active_level))
    else $error("switch to lower priority level");
  a_mask_gates: assert property (@(posedge mclk) disable iff (sys_rst)
    vector_valid |-> $past(level_mask[req_level]) && $past(dev_en[addr_s2]))
    else $error("masked request accepted");
  a_class_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    class_active && !class_reset |=> class_active && !vector_valid)
    else $error("class interrupt dropped or preempted");
  a_mask_write: assert property (@(posedge mclk) disable iff (sys_rst)
    level_mask_we |=> level_mask == $past(level_mask_in))
    else $error("mask write lost");
  a_reset_state: assert property (@(posedge mclk)
    sys_rst |=> active_level == `PLIS_LEVEL_RESET && level_mask == NL'(`PLIS_MASK_RESET)
    && !class_active && !dev_ack)
    else $error("reset state wrong");
  // pointer written, level left, then re-entered: the old pointer must reappear
  a_bank_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    ptr_we ##1 s_prog_switch ##1 s_prog_switch ##0 (prog_level == $past(active_level, 2))
    |=> level_instruction_pointer == $past(ptr_wdata, 3))
    else $error("level context lost");
endmodule
`default_nettype wire

// ### testbench/plis_dev_model.sv
/*
  behavioural i/o device attachment that raises vectored requests.
  assumes one mclk domain and the switch's request/acknowledge handshake.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plis_regs.svh"
module plis_dev_model (
  input  wire logic                   mclk,
  output logic                        dev_req,
  output logic [`PLIS_DEV_W-1:0]      dev_addr,
  input  wire logic                   dev_ack,
  input  wire logic                   vector_valid,
  input  wire logic [`PLIS_ADDR_W-1:0] vector_entry
);
  initial begin
    dev_req  = 1'b0;
    dev_addr = 8'h00;
  end
  // hold request and address until ack is seen, give up after eight cycles
  task automatic request(input logic [7:0] a, output bit ok, output logic [15:0] vec);
    int n;
    ok  = 1'b0;
    vec = 16'h0000;
    @(posedge mclk);
    dev_req  <= 1'b1;
    dev_addr <= a;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge mclk);
      if (dev_ack === 1'b1 && vector_valid === 1'b1) begin
        ok  = 1'b1;
        vec = vector_entry;
      end
    end
    @(posedge mclk);
    dev_req  <= 1'b0;
    dev_addr <= ~a; // released bus shows no stale address
  endtask
endmodule
`default_nettype wire

// ### testbench/priority_level_interrupt_switch_test.sv
/*
  self-checking bench for the priority level interrupt switch.
  assumes plis_top with its translator and the device model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plis_regs.svh"
module priority_level_interrupt_switch_test;
  logic        mclk = '0, sys_rst = 1'b1, level_mask_we = '0, dev_cfg_we = '0;
  logic        dev_cfg_enable = '0, prog_switch = '0, class_set = '0, class_reset = '0;
  logic        gpr_we = '0, ptr_we = '0, lsw_we = '0, xlat_en = '0, seg_we = '0;
  logic [3:0]  level_mask_in = '0, level_mask;
  logic [7:0]  dev_cfg_addr = '0, dev_addr;
  logic [1:0]  dev_cfg_level = '0, prog_level = '0, active_level;
  logic [2:0]  gpr_sel = '0, seg_sel = '0;
  logic [15:0] gpr_wdata = '0, ptr_wdata = '0, lsw_wdata = '0, mem_addr = '0;
  logic [10:0] seg_base = '0;
  logic        dev_req, dev_ack, class_active, vector_valid;
  logic [15:0] vector_entry, gpr_rdata, level_instruction_pointer, level_status_word;
  logic [23:0] phys_addr;
  logic [31:0] rnd = 32'hdc6b_3eef;
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  int          m_lvl = 0, m_mask = 0, m_cls = 0;
  int          m_gpr[4][8], m_ptr[4], m_lsw[4], m_den[256], m_dlv[256], m_seg[8];

  plis_top plis_top_inst (
    .mclk                      (mclk),
    .sys_rst                   (sys_rst),
    .dev_req                   (dev_req),
    .dev_addr                  (dev_addr),
    .dev_ack                   (dev_ack),
    .level_mask_we             (level_mask_we),
    .level_mask_in             (level_mask_in),
    .dev_cfg_we                (dev_cfg_we),
    .dev_cfg_addr              (dev_cfg_addr),
    .dev_cfg_enable            (dev_cfg_enable),
    .dev_cfg_level             (dev_cfg_level),
    .prog_switch               (prog_switch),
    .prog_level                (prog_level),
    .class_set                 (class_set),
    .class_reset               (class_reset),
    .gpr_we                    (gpr_we),
    .gpr_sel                   (gpr_sel),
    .gpr_wdata                 (gpr_wdata),
    .ptr_we                    (ptr_we),
    .ptr_wdata                 (ptr_wdata),
    .lsw_we                    (lsw_we),
    .lsw_wdata                 (lsw_wdata),
    .mem_addr                  (mem_addr),
    .xlat_en                   (xlat_en),
    .seg_we                    (seg_we),
    .seg_sel                   (seg_sel),
    .seg_base                  (seg_base),
    .active_level              (active_level),
    .class_active              (class_active),
    .vector_valid              (vector_valid),
    .vector_entry              (vector_entry),
    .gpr_rdata                 (gpr_rdata),
    .level_instruction_pointer (level_instruction_pointer),
    .level_status_word         (level_status_word),
    .phys_addr                 (phys_addr),
    .level_mask                (level_mask)
  );
  plis_dev_model plis_dev_model_inst (.mclk(mclk), .dev_req(dev_req), .dev_addr(dev_addr),
    .dev_ack(dev_ack), .vector_valid(vector_valid), .vector_entry(vector_entry));

  // clock and hang guard
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // one step of the stimulus lfsr
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic setmask(input logic [3:0] m);
    @(posedge mclk);
    level_mask_we <= 1;
    level_mask_in <= m;
    @(posedge mclk);
    level_mask_we <= 0;
    m_mask = m;
    @(negedge mclk);
    chk(level_mask, m);
  endtask
  task automatic swto(input int l);
    @(posedge mclk);
    prog_switch <= 1;
    prog_level  <= l[1:0];
    @(posedge mclk);
    prog_switch <= 0;
    m_lvl = l;
    @(negedge mclk);
    chk(active_level, l);
  endtask
  // write one register of the active bank, pointer and status on the first two
  task automatic wr(input int s);
    rnd = lfsr(rnd);
    @(posedge mclk);
    gpr_we    <= 1'b1;
    gpr_sel   <= s[2:0];
    gpr_wdata <= rnd[15:0];
    ptr_we    <= (s == 0);
    ptr_wdata <= rnd[31:16];
    lsw_we    <= (s == 1);
    lsw_wdata <= rnd[31:16];
    m_gpr[m_lvl][s] = rnd[15:0];
    if (s == 0) m_ptr[m_lvl] = rnd[31:16];
    if (s == 1) m_lsw[m_lvl] = rnd[31:16];
    @(posedge mclk);
    gpr_we <= 1'b0;
    ptr_we <= 1'b0;
    lsw_we <= 1'b0;
  endtask
  task automatic rd(input int s);
    @(posedge mclk);
    gpr_sel <= s[2:0];
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(gpr_rdata, m_gpr[m_lvl][s]);
    chk(level_instruction_pointer, m_ptr[m_lvl]);
    chk(level_status_word, m_lsw[m_lvl]);
  endtask
  // pointer write, then switch away and straight back on two adjacent edges
  task automatic kept(input int l);
    rnd = lfsr(rnd);
    @(posedge mclk);
    ptr_we    <= 1'b1;
    ptr_wdata <= rnd[15:0];
    m_ptr[m_lvl] = rnd[15:0];
    @(posedge mclk);
    ptr_we      <= 1'b0;
    prog_switch <= 1'b1;
    prog_level  <= l[1:0];
    @(posedge mclk);
    prog_level <= m_lvl[1:0];
    @(posedge mclk);
    prog_switch <= 1'b0;
    @(negedge mclk);
    chk(active_level, m_lvl);
    chk(level_instruction_pointer, m_ptr[m_lvl]);
  endtask
  task automatic cfg(input logic [7:0] a, input int en, input int lv);
    @(posedge mclk);
    dev_cfg_we     <= 1'b1;
    dev_cfg_addr   <= a;
    dev_cfg_enable <= en[0];
    dev_cfg_level  <= lv[1:0];
    @(posedge mclk);
    dev_cfg_we <= 1'b0;
    m_den[a] = en;
    m_dlv[a] = lv;
  endtask
  task automatic cls(input int s);
    @(posedge mclk);
    class_set   <= s[0];
    class_reset <= !s[0];
    @(posedge mclk);
    class_set   <= 1'b0;
    class_reset <= 1'b0;
    m_cls = s;
    @(negedge mclk);
    chk(class_active, s);
  endtask
  // request from the device model, acceptance predicted from the model state
  task automatic dreq(input logic [7:0] a);
    bit ok;
    logic [15:0] v;
    bit e;
    e = m_den[a] != 0 && m_mask[m_dlv[a]] && m_dlv[a] < m_lvl && m_cls == 0;
    plis_dev_model_inst.request(a, ok, v);
    chk(ok, e);
    if (e) begin
      m_lvl = m_dlv[a];
      chk(v, a * 4);
    end
    @(negedge mclk);
    chk(active_level, m_lvl);
  endtask

  // main sequence
  initial begin
    int i, s;
    logic [15:0] a;
    logic [23:0] e;
    repeat (16) @(posedge mclk);
    sys_rst <= 0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(active_level, 0);
    chk(level_mask, 0);
    chk(class_active, 0);
    setmask(4'hf);
    for (i = 0; i < 4; i++) begin
      swto(3 - i);
      for (s = 0; s < 8; s++) wr(s);
    end
    for (i = 0; i < 4; i++) begin
      swto(i);
      for (s = 0; s < 8; s++) rd(s);
    end
    kept(1);
    swto(3);
    cfg(8'h5a, 1, 1);
    dreq(8'h5a);
    cfg(8'h33, 1, 2);
    dreq(8'h33);
    swto(3);
    cfg(8'h5a, 1, 2);
    dreq(8'h5a);
    cfg(8'hff, 0, 0);
    dreq(8'hff);
    cfg(8'hff, 1, 0);
    setmask(4'he);
    dreq(8'hff);
    cls(1);
    setmask(4'hf);
    dreq(8'hff);
    cls(0);
    dreq(8'hff);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      @(posedge mclk);
      seg_we   <= 1'b1;
      seg_sel  <= i[2:0];
      seg_base <= rnd[10:0];
      m_seg[i] = rnd[10:0];
      @(posedge mclk);
      seg_we <= 1'b0;
    end
    for (i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      a = (i == 0) ? 16'hffff : rnd[15:0];
      e = rnd[16] ? {m_seg[a[15:13]][10:0], a[12:0]} : {8'h00, a};
      @(posedge mclk);
      mem_addr <= a;
      xlat_en  <= rnd[16];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk(phys_addr, e);
    end
    complete_run();
  end
endmodule
`default_nettype wire
